// ===== logic/ccms_pkg.sv
// constants and types shared by the core clock mode select block
package ccms_pkg;
  localparam int CLK_MHZ = 100;
  // free-running PLL clock period, in ns; cycles derived, rounded up
  localparam int PLL_FREE_NS = 40;
  localparam int PLL_FREE_CYC = (PLL_FREE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PLL_DIV_LAST = 4'(PLL_FREE_CYC - 1);
  localparam logic [4:0] WDOG_OVF = 5'h10;
  localparam int WDOG_DIS_BIT = 4;
  localparam int PW = 16;
  // select pin codes
  localparam logic [2:0] SEL_X4 = 3'h7;
  localparam logic [2:0] SEL_X3 = 3'h6;
  localparam logic [2:0] SEL_X2 = 3'h5;
  localparam logic [2:0] SEL_X5 = 3'h4;
  localparam logic [2:0] SEL_DIRECT = 3'h3;
  localparam logic [2:0] SEL_X1_5 = 3'h2;
  localparam logic [2:0] SEL_PRESCALE = 3'h1;
  localparam logic [2:0] SEL_X2_5 = 3'h0;
  localparam logic [2:0] SEL_RESET = SEL_X4;
  // core edges per input period (twice the factor)
  localparam logic [3:0] F2_X4 = 4'h8;
  localparam logic [3:0] F2_X3 = 4'h6;
  localparam logic [3:0] F2_X2 = 4'h4;
  localparam logic [3:0] F2_X5 = 4'ha;
  localparam logic [3:0] F2_X1_5 = 4'h3;
  localparam logic [3:0] F2_X2_5 = 4'h5;
  localparam logic [1:0] CAP_AT = 2'h2;
  typedef enum logic [1:0] {
    CCMS_DIRECT,
    CCMS_PRESCALE,
    CCMS_PLL
  } ccms_mode_t;
endpackage

// ===== logic/ccms_edge_if.sv
// carrier between the mode control and the fractional edge generator
interface ccms_edge_if;
  logic run;
  logic [ccms_pkg::PW-1:0] period;
  logic [3:0] f2;
  logic edge_p;
  modport gen (input run, input period, input f2, output edge_p);
  modport ctl (output run, output period, output f2, input edge_p);
endinterface

// ===== logic/ccms_edge_gen.sv
// fractional edge generator: f2 evenly spread edges per input period
module ccms_edge_gen (
  input wire logic clk_i,      // system clock
  input wire logic rst_n_i,    // synchronised reset, active low
  ccms_edge_if.gen eif         // period and factor in, edge out
);
  typedef struct packed {
    logic [ccms_pkg::PW:0] acc;
    logic edge_p;
  } ccms_eg_t;

  ccms_eg_t st, next_st;
  logic [ccms_pkg::PW:0] sum;

  // accumulator spreads edges; a new period only changes the wrap point,
  // never the phase, so the frequency moves without a jump
  always_comb begin
    next_st = st;
    next_st.edge_p = 1'b0;
    sum = st.acc + {13'h0, eif.f2};
    if (!eif.run || eif.period == '0) begin
      next_st.acc = '0;
    end else if (sum >= {1'b0, eif.period}) begin
      next_st.edge_p = 1'b1;
      next_st.acc = sum - {1'b0, eif.period};
    end else begin
      next_st.acc = sum;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign eif.edge_p = st.edge_p;
endmodule // ccms_edge_gen

// ===== logic/ccms_clock_mode_select.sv
// core clock mode select: direct, prescaled, PLL and oscillator watchdog
module ccms_clock_mode_select (
  input wire logic clk_i,                   // 100 MHz system clock
  input wire logic arst_n_i,                // async reset, active low
  input wire logic crystal_input_i,         // input clock pin
  input wire logic [2:0] clock_select_pins_i, // mode strap pins
  input wire logic osc_watchdog_disable_i,  // config bit 4, 1 = off
  output logic core_clk_o,                  // generated core clock
  output logic core_rise_o,                 // pulse on rising edge
  output logic core_fall_o,                 // pulse on falling edge
  output logic pll_on_o,                    // PLL running
  output logic osc_fail_int_request_o,      // sticky oscillator fail
  output logic [2:0] clock_select_bits_o    // captured select code
);
  typedef struct packed {
    logic [1:0] cap_cnt;
    logic sel_done;
    logic [2:0] sel;
    logic xs1;
    logic xs2;
    logic xprev;
    logic [2:0] ps1;
    logic [2:0] ps2;
    logic wdog_dis;
    logic [3:0] pll_div;
    logic [4:0] wd_cnt;
    logic fail;
    logic [ccms_pkg::PW-1:0] per_cnt;
    logic [ccms_pkg::PW-1:0] per_meas;
    logic [ccms_pkg::PW-1:0] per_use;
    logic [3:0] trn_cnt;
    logic core;
    logic rise;
    logic fall;
  } ccms_state_t;

  ccms_state_t st, next_st;
  logic rst_meta, rst_n;
  ccms_edge_if eif ();

  ccms_edge_gen u_edge (
    .clk_i (clk_i),
    .rst_n_i (rst_n),
    .eif (eif.gen)
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ccms_pkg::ccms_mode_t mode;
  logic [3:0] f2;
  logic trans, rise_x, pll_run, pll_tick, wd_active;

  // select code to mode and factor
  always_comb begin
    mode = ccms_pkg::CCMS_PLL;
    f2 = ccms_pkg::F2_X4;
    unique case (st.sel)
      ccms_pkg::SEL_X4: f2 = ccms_pkg::F2_X4;
      ccms_pkg::SEL_X3: f2 = ccms_pkg::F2_X3;
      ccms_pkg::SEL_X2: f2 = ccms_pkg::F2_X2;
      ccms_pkg::SEL_X5: f2 = ccms_pkg::F2_X5;
      ccms_pkg::SEL_DIRECT: mode = ccms_pkg::CCMS_DIRECT;
      ccms_pkg::SEL_X1_5: f2 = ccms_pkg::F2_X1_5;
      ccms_pkg::SEL_PRESCALE: mode = ccms_pkg::CCMS_PRESCALE;
      ccms_pkg::SEL_X2_5: f2 = ccms_pkg::F2_X2_5;
    endcase
  end

  always_comb begin
    next_st = st;
    // only the second stage of each synchroniser is looked at
    next_st.xs1 = crystal_input_i;
    next_st.xs2 = st.xs1;
    next_st.xprev = st.xs2;
    next_st.ps1 = clock_select_pins_i;
    next_st.ps2 = st.ps1;
    trans = st.xs2 ^ st.xprev;
    rise_x = st.xs2 & ~st.xprev;

    // strap caught once, after the pin synchroniser has filled
    if (!st.sel_done) begin
      next_st.cap_cnt = st.cap_cnt + 2'h1;
      if (st.cap_cnt == ccms_pkg::CAP_AT) begin
        next_st.sel = st.ps2;
        next_st.sel_done = 1'b1;
      end
    end

    next_st.wdog_dis = osc_watchdog_disable_i;

    // free-running PLL stays on while the watchdog needs it
    pll_run = (mode == ccms_pkg::CCMS_PLL) | ~st.wdog_dis | st.fail;
    pll_tick = pll_run && (st.pll_div == ccms_pkg::PLL_DIV_LAST);
    if (!pll_run || pll_tick) begin
      next_st.pll_div = '0;
    end else begin
      next_st.pll_div = st.pll_div + 4'h1;
    end

    // watchdog: tick counts, any input transition clears
    wd_active = (mode != ccms_pkg::CCMS_PLL) && !st.wdog_dis
      && !st.fail && st.sel_done;
    if (!wd_active || trans) begin
      next_st.wd_cnt = '0;
    end else if (pll_tick) begin
      next_st.wd_cnt = st.wd_cnt + 5'h1;
      if (st.wd_cnt + 5'h1 == ccms_pkg::WDOG_OVF) begin
        next_st.fail = 1'b1;
      end
    end

    // input period, rising to rising, in system cycles
    if (rise_x) begin
      next_st.per_meas = st.per_cnt + 16'h1;
      next_st.per_cnt = '0;
    end else if (st.per_cnt != 16'hffff) begin
      next_st.per_cnt = st.per_cnt + 16'h1;
    end
    // new period taken on every f2-th input transition
    if (trans) begin
      if (st.trn_cnt + 4'h1 >= f2) begin
        next_st.trn_cnt = '0;
        next_st.per_use = st.per_meas;
      end else begin
        next_st.trn_cnt = st.trn_cnt + 4'h1;
      end
    end

    // core clock source; a failed oscillator never hands back
    if (!st.sel_done) begin
      next_st.core = 1'b0;
    end else if (st.fail) begin
      next_st.core = st.core ^ pll_tick;
    end else begin
      unique case (mode)
        ccms_pkg::CCMS_DIRECT: next_st.core = st.xs2;
        ccms_pkg::CCMS_PRESCALE: next_st.core = st.core ^ rise_x;
        ccms_pkg::CCMS_PLL: next_st.core = st.core ^ eif.edge_p;
      endcase
    end
    next_st.rise = next_st.core & ~st.core;
    next_st.fall = ~next_st.core & st.core;
  end

  assign eif.run = st.sel_done && (mode == ccms_pkg::CCMS_PLL);
  assign eif.period = st.per_use;
  assign eif.f2 = f2;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.sel <= ccms_pkg::SEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign core_clk_o = st.core;
  assign core_rise_o = st.rise;
  assign core_fall_o = st.fall;
  assign pll_on_o = pll_run;
  assign osc_fail_int_request_o = st.fail;
  assign clock_select_bits_o = st.sel;
endmodule // ccms_clock_mode_select

// ===== test/ccms_asserts.sv
// checker for the core clock mode select block
module ccms_asserts (
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic crystal_input_i, // input clock
  input wire logic [2:0] clock_select_pins_i, // straps
  input wire logic osc_watchdog_disable_i, // watchdog off
  input wire logic core_clk_o, // core clock
  input wire logic core_rise_o, // rise pulse
  input wire logic core_fall_o, // fall pulse
  input wire logic pll_on_o, // pll running
  input wire logic osc_fail_int_request_o, // fail flag
  input wire logic [2:0] clock_select_bits_o // code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] quiet;
  logic npll;
  assign npll = clock_select_bits_o inside {3'h1, 3'h3};
  // cycles since the input pin last moved, saturating
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet <= 7'h0;
    else if ($changed(crystal_input_i)) quiet <= 7'h0;
    else if (quiet != 7'h7f) quiet <= quiet + 7'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  rise_pulse_a: assert property (core_rise_o == $rose(core_clk_o))
    else $error("rise pulse mismatch");
  fall_pulse_a: assert property (core_fall_o == $fell(core_clk_o))
    else $error("fall pulse mismatch");
  code_hold_a: assert property (clock_select_bits_o != 3'h7 |=>
    $stable(clock_select_bits_o)) else $error("code changed");
  direct_drive_a: assert property (clock_select_bits_o == 3'h3 &&
    $past(clock_select_bits_o) == 3'h3 && !osc_fail_int_request_o
    |-> core_clk_o == $past(crystal_input_i, 3))
    else $error("direct clock wrong");
  prescale_edge_a: assert property (clock_select_bits_o == 3'h1 &&
    !osc_fail_int_request_o && (core_rise_o || core_fall_o)
    |-> $past(crystal_input_i, 3) && !$past(crystal_input_i, 4))
    else $error("prescale edge wrong");
  pll_run_a: assert property (pll_on_o == (osc_fail_int_request_o ||
    !npll || !$past(osc_watchdog_disable_i)))
    else $error("pll enable wrong");
  fail_sticky_a: assert property (osc_fail_int_request_o |=>
    osc_fail_int_request_o) else $error("fail flag dropped");
  wdog_late_a: assert property (npll && !osc_watchdog_disable_i &&
    quiet == 7'h50 |-> osc_fail_int_request_o)
    else $error("watchdog missed stop");
  wdog_early_a: assert property ($rose(osc_fail_int_request_o)
    |-> quiet > 7'h3c) else $error("watchdog too early");
endmodule // ccms_asserts
bind ccms_clock_mode_select ccms_asserts i_ccms_asserts (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .crystal_input_i(crystal_input_i),
  .clock_select_pins_i(clock_select_pins_i),
  .osc_watchdog_disable_i(osc_watchdog_disable_i),
  .core_clk_o(core_clk_o), .core_rise_o(core_rise_o),
  .core_fall_o(core_fall_o), .pll_on_o(pll_on_o),
  .osc_fail_int_request_o(osc_fail_int_request_o),
  .clock_select_bits_o(clock_select_bits_o));

// ===== test/ccms_xtal_model.sv
// external clock source on the input clock pin
module ccms_xtal_model (
  input wire logic run_i, // source present
  input var int hi_i, // high time, ns
  input var int lo_i, // low time, ns
  output logic xtal_o // pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a failed source parks low, as a dead oscillator would
  initial begin
    xtal_o = 1'b0;
    forever begin
      wait (run_i);
      xtal_o = 1'b1;
      #(hi_i);
      xtal_o = 1'b0;
      #(lo_i);
    end
  end
endmodule // ccms_xtal_model

// ===== test/ccms_clock_mode_select_tb_top.sv
// self-checking bench for the core clock mode select block
module ccms_clock_mode_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F2[8] = '{5, 0, 3, 0, 10, 4, 6, 8};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] pins = 3'h7;
  logic dis = 1'b0;
  logic run = 1'b1;
  int hi = 600;
  int lo = 600;
  int cyc = 0;
  int last = 0;
  int pe;
  int per = 1200;
  int hl;
  int hi_len = 0;
  int mismatches = 0;
  int n_compared = 0;
  logic xtal, core_clk, rise, fall, fail;
  logic [2:0] bits;
  logic [35:0] q[$];
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ccms_xtal_model i_ccms_xtal_model (.run_i(run), .hi_i(hi), .lo_i(lo),
    .xtal_o(xtal));
  ccms_clock_mode_select i_ccms_clock_mode_select (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .crystal_input_i(xtal),
    .clock_select_pins_i(pins), .osc_watchdog_disable_i(dis),
    .core_clk_o(core_clk), .core_rise_o(rise), .core_fall_o(fall),
    .pll_on_o(), .osc_fail_int_request_o(fail),
    .clock_select_bits_o(bits));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic note(input logic f, input logic [2:0] c, input int p,
    input int h);
    int k;
    k = 0;
    q.push_back({f, c, 16'(h), 16'(p)});
    while (q.size() > 0 && k < 3000) begin
      tick(1);
      k++;
    end
    if (q.size() > 0) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // straps held through reset, then scrambled to prove they are ignored
  task automatic boot(input logic [2:0] c, input logic d);
    arst_n_i = 1'b0;
    pins = c;
    dis = d;
    tick(3);
    arst_n_i = 1'b1;
    tick(12);
    pins = 3'($urandom);
    tick(1500);
  endtask
  // result: core period and high time, with code and flag
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (fall && last > 0) hi_len <= cyc - last;
    if (rise && q.size() > 0) begin
      if (last > 0) begin
        chk(q[0][15:0], 16'(cyc - last));
        chk(q[0][31:16], 16'(hi_len));
        chk(16'(q[0][34:32]), 16'(bits));
        chk(16'(q[0][35]), 16'(fail));
        void'(q.pop_front());
        last <= 0;
      end else last <= cyc;
    end
  end
  initial begin
    void'($urandom(83));
    // pll modes: a 1200 ns period divides evenly for every factor;
    // 600 ns elsewhere keeps each half below the 64-cycle watchdog
    for (int c = 0; c < 8; c++) begin
      per = (c == 1 || c == 3) ? 600 : 1200;
      hi = 10 * (20 + $urandom % ((c == 1 || c == 3) ? 21 : 80));
      lo = per - hi;
      // let a long half period of the old setting run out first
      if (c != 0) tick(110);
      pe = (c == 1) ? per / 5 : (c == 3) ? per / 10 : 240 / F2[c];
      hl = (c == 1) ? per / 10 : (c == 3) ? hi / 10 : pe / 2;
      boot(3'(c), 1'($urandom));
      note(1'b0, 3'(c), pe, hl);
      $display("mode %0d done", c);
    end
    hi = 300;
    lo = 300;
    tick(110);
    boot(3'h3, 1'b0);
    run = 1'b0;
    tick(100);
    note(1'b1, 3'h3, 8, 4);
    run = 1'b1;
    tick(300);
    note(1'b1, 3'h3, 8, 4);
    $display("watchdog test done");
    boot(3'h1, 1'b1);
    run = 1'b0;
    tick(200);
    run = 1'b1;
    tick(300);
    note(1'b0, 3'h1, 120, 60);
    $display("watchdog off test done");
    print_verdict();
  end
endmodule // ccms_clock_mode_select_tb_top
